// File: scu_uart.v
// Serial controller in UART mode: Avalon-MM registers, transmit and receive FIFOs,
// frame engine and request-to-send handshake.
// Assumes inputs synchronous to i_clock (the 24 MHz reference) and a 32-bit Avalon-MM master.
`include "scu_defines.vh"
// Behaviour
// - Mode field: 0 off, 1 UART, 2 SPI, 3 I2C.
// - Writing the data port pushes a byte onto the transmit FIFO.
// - Reading the data port pops the oldest receive byte.
// - Bit rate is reference divided by twice (N + F/2).
// - Fraction bit zero adds half a period unit.
// - Config bit six hands request-to-send to hardware.
// - Automatic mode deasserts request-to-send when one slot remains.
// - Automatic mode reasserts when more than one slot remains.
// - Software request bit ignored while automatic mode is on.
// - Software bit set drives output low; cleared drives it high.
// - Bit five enables handshake; cleared forces clear-to-send asserted.
// - Config bits four to one choose parity, stop bits and data width.
module scu_uart #(
   parameter FIFO_LOG2 = 2
) (
   input wire i_clock,
   input wire i_resetn,
   input wire [`SCU_ADDR_W-1:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [31:0] i_writedata,
   input wire [3:0] i_byteenable,
   output reg [31:0] o_readdata,
   output reg o_waitrequest,
   input wire i_rx,
   input wire i_clear_to_send_in_n,
   output reg o_tx,
   output reg o_ready_to_receive_n
);
   // Receive FIFO depth, used to turn the occupancy into free slots.
   localparam [FIFO_LOG2:0] RX_DEPTH = 1 << FIFO_LOG2;
   // Transmitter states.
   localparam TX_IDLE = 2'h0;
   localparam TX_SHIFT = 2'h1;
   localparam TX_STOP = 2'h2;
   // Receiver states.
   localparam RX_IDLE = 2'h0;
   localparam RX_SHIFT = 2'h1;
   localparam RX_STOP = 2'h2;

   // Software-visible registers.
   reg [1:0] mode_reg;
   reg [`SCU_CFG_W-1:0] cfg_reg;
   reg [15:0] per_reg;
   reg frac_reg;

   // Transmitter state.
   reg [1:0] tx_state_reg;
   reg [10:0] tx_shift_reg;
   reg [3:0] tx_bits_reg;
   reg tx_half_reg;

   // Receiver state.
   reg [1:0] rx_state_reg;
   reg [8:0] rx_shift_reg;
   reg [3:0] rx_bits_reg;
   reg [4:0] rx_half_reg;
   reg rx_push_reg;
   reg [7:0] rx_byte_reg;

   // Bus decode: word index, mode and byte lanes.
   wire [15:0] word_idx = i_address[`SCU_ADDR_W-1:2];
   wire uart_on = (mode_reg == `SCU_MODE_UART);
   wire lo_en = i_byteenable[0];
   wire hi_en = i_byteenable[1];

   // A request counts while waitrequest is high, so the answer cycle never takes it twice.
   wire req = (i_read || i_write) && o_waitrequest;

   // Links to the FIFOs and the baud generator.
   wire tick;
   wire [7:0] tx_fifo_data;
   wire tx_empty;
   wire [7:0] rx_fifo_data;
   wire rx_empty;
   wire rx_full;
   wire [FIFO_LOG2:0] rx_count;

   // Format and handshake fields.
   wire eight = cfg_reg[`SCU_CFG_8BIT];
   wire par_on = cfg_reg[`SCU_CFG_PAR];
   wire odd = cfg_reg[`SCU_CFG_ODD];
   wire two_stop = cfg_reg[`SCU_CFG_2STP];
   wire flow_on = cfg_reg[`SCU_CFG_FLOW];
   wire cts_ok = !flow_on || !i_clear_to_send_in_n;

   // Transmit byte, its parity and the data plus parity bit count.
   wire [7:0] tx_byte = eight ? tx_fifo_data : {1'b0, tx_fifo_data[6:0]};
   wire tx_par = ^tx_byte ^ odd;
   wire [3:0] data_bits = eight ? 4'h8 : 4'h7;
   wire [3:0] frame_bits = data_bits + {3'h0, par_on};

   // Frames start on a tick so that their bits line up with the baud grid.
   wire tx_start = uart_on && (tx_state_reg == TX_IDLE) && !tx_empty && cts_ok && tick;
   wire tx_pop = tx_start;

   // Data-port strobes; the FIFO connections gate them with the mode.
   wire bus_wr_data = req && i_write && (word_idx == `SCU_IDX_DATA) && lo_en;
   wire bus_rd_data = req && i_read && (word_idx == `SCU_IDX_DATA);

   // Free receive slots for the automatic request-to-send.
   wire [FIFO_LOG2:0] rx_room = RX_DEPTH - rx_count;

   // Transmit FIFO: filled by data-port writes, emptied outside UART mode.
   scu_fifo #(
      .WIDTH(8),
      .DEPTH_LOG2(FIFO_LOG2)
   ) u_tx_fifo (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_clear(!uart_on),
      .i_push(bus_wr_data && uart_on),
      .i_data(i_writedata[7:0]),
      .i_pop(tx_pop),
      .o_data(tx_fifo_data),
      .o_empty(tx_empty),
      .o_full(),
      .o_count()
   );

   // Receive FIFO: filled by the receiver, drained by data-port reads.
   scu_fifo #(
      .WIDTH(8),
      .DEPTH_LOG2(FIFO_LOG2)
   ) u_rx_fifo (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_clear(!uart_on),
      .i_push(rx_push_reg),
      .i_data(rx_byte_reg),
      .i_pop(bus_rd_data && uart_on),
      .o_data(rx_fifo_data),
      .o_empty(rx_empty),
      .o_full(rx_full),
      .o_count(rx_count)
   );

   // Half-bit tick source, held cleared outside UART mode.
   scu_baud u_baud (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_run(uart_on),
      .i_period(per_reg),
      .i_frac(frac_reg),
      .o_tick(tick)
   );

   // Bus slave: every request is answered one cycle after it is seen.
   // Writes and reads are taken on that first edge; the master holds them through the answer.
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h00000000;
         mode_reg <= `SCU_RST_MODE;
         cfg_reg <= `SCU_RST_CFG;
         per_reg <= `SCU_RST_PER;
         frac_reg <= `SCU_RST_FRAC;
      end else begin
         // Waitrequest drops for the one cycle after a request, straight from this flop.
         o_waitrequest <= !req;
         if (req && i_write) begin
            case (word_idx)
               `SCU_IDX_MODE: begin
                  if (lo_en) begin
                     mode_reg <= i_writedata[1:0];
                  end
               end
               `SCU_IDX_CFG: begin
                  if (lo_en) begin
                     cfg_reg <= i_writedata[`SCU_CFG_W-1:0];
                  end
               end
               `SCU_IDX_PER: begin
                  if (lo_en) begin
                     per_reg[7:0] <= i_writedata[7:0];
                  end
                  if (hi_en) begin
                     per_reg[15:8] <= i_writedata[15:8];
                  end
               end
               `SCU_IDX_FRAC: begin
                  if (lo_en) begin
                     frac_reg <= i_writedata[0];
                  end
               end
               default: begin
               end
            endcase
         end
         if (req && i_read) begin
            case (word_idx)
               `SCU_IDX_DATA: o_readdata <= {24'h000000, (uart_on && !rx_empty) ? rx_fifo_data : 8'h00};
               `SCU_IDX_MODE: o_readdata <= {30'h00000000, mode_reg};
               `SCU_IDX_CFG: o_readdata <= {25'h0000000, cfg_reg};
               `SCU_IDX_PER: o_readdata <= {16'h0000, per_reg};
               `SCU_IDX_FRAC: o_readdata <= {31'h00000000, frac_reg};
               default: o_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Transmitter: each bit lasts two half-bit ticks; frame built at start.
   // Leaving UART mode aborts a frame and parks the line high at once.
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 11'h7ff;
         tx_bits_reg <= 4'h0;
         tx_half_reg <= 1'b0;
         o_tx <= 1'b1;
      end else if (!uart_on) begin
         tx_state_reg <= TX_IDLE;
         tx_half_reg <= 1'b0;
         o_tx <= 1'b1;
      end else begin
         case (tx_state_reg)
            // Waits for a byte, a tick and clear-to-send.
            TX_IDLE: begin
               if (tx_start) begin
                  // Data LSB first, then parity if enabled, then stop ones.
                  tx_shift_reg <= par_on ? (eight ? {2'h3, tx_par, tx_byte} : {3'h7, tx_par, tx_byte[6:0]})
                     : (eight ? {3'h7, tx_byte} : {4'hf, tx_byte[6:0]});
                  tx_bits_reg <= frame_bits;
                  tx_half_reg <= 1'b0;
                  o_tx <= 1'b0;
                  tx_state_reg <= TX_SHIFT;
               end
            end
            // Every second tick ends a bit; after the last one the line goes high for the stops.
            TX_SHIFT: begin
               if (tick) begin
                  tx_half_reg <= ~tx_half_reg;
                  if (tx_half_reg) begin
                     o_tx <= tx_shift_reg[0];
                     tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                     if (tx_bits_reg == 4'h0) begin
                        o_tx <= 1'b1;
                        tx_bits_reg <= two_stop ? 4'h1 : 4'h0;
                        tx_state_reg <= TX_STOP;
                     end else begin
                        tx_bits_reg <= tx_bits_reg - 4'h1;
                     end
                  end
               end
            end
            TX_STOP: begin
               // Idle is entered for the last half of the final stop bit, so a queued frame
               // starts on the next tick and every stop bit lasts exactly one bit time.
               if (tick) begin
                  tx_half_reg <= ~tx_half_reg;
                  if (tx_half_reg) begin
                     tx_bits_reg <= tx_bits_reg - 4'h1;
                  end else if (tx_bits_reg == 4'h0) begin
                     tx_state_reg <= TX_IDLE;
                  end
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // Receiver: samples mid-bit, discards the frame on a low stop bit or full FIFO.
   // Parity is not checked; a start is seen on the first tick that finds the line low.
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 9'h000;
         rx_bits_reg <= 4'h0;
         rx_half_reg <= 5'h00;
         rx_push_reg <= 1'b0;
         rx_byte_reg <= 8'h00;
      end else begin
         rx_push_reg <= 1'b0;
         if (!uart_on) begin
            rx_state_reg <= RX_IDLE;
         end else begin
            case (rx_state_reg)
               RX_IDLE: begin
                  if (tick && !i_rx) begin
                     rx_half_reg <= 5'h01; // Middle of start bit is one tick on.
                     rx_bits_reg <= frame_bits;
                     rx_state_reg <= RX_SHIFT;
                  end
               end
               // Alternate ticks: skip the bit edge, then sample the bit middle.
               RX_SHIFT: begin
                  if (tick) begin
                     if (rx_half_reg == 5'h01) begin
                        rx_half_reg <= 5'h00;
                     end else begin
                        rx_half_reg <= 5'h01;
                        rx_shift_reg <= {i_rx, rx_shift_reg[8:1]};
                        if (rx_bits_reg == 4'h1) begin
                           rx_state_reg <= RX_STOP;
                        end
                        rx_bits_reg <= rx_bits_reg - 4'h1;
                     end
                  end
               end
               // The stop bit is sampled in its middle; a low one drops the frame.
               RX_STOP: begin
                  if (tick) begin
                     if (rx_half_reg == 5'h01) begin
                        rx_half_reg <= 5'h00;
                     end else begin
                        rx_state_reg <= RX_IDLE;
                        rx_push_reg <= i_rx && !rx_full;
                        // Realign the left-justified frame to the data bits.
                        case ({eight, par_on})
                           2'b11: rx_byte_reg <= rx_shift_reg[7:0];
                           2'b10: rx_byte_reg <= rx_shift_reg[8:1];
                           2'b01: rx_byte_reg <= {1'b0, rx_shift_reg[7:1]};
                           default: rx_byte_reg <= {1'b0, rx_shift_reg[8:2]};
                        endcase
                     end
                  end
               end
               default: rx_state_reg <= RX_IDLE;
            endcase
         end
      end
   end

   // Request-to-send: hardware watches receive room when automatic, else follows software.
   // Without handshake or outside UART mode it stays high, so the partner holds off.
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_ready_to_receive_n <= 1'b1;
      end else if (!flow_on || !uart_on) begin
         o_ready_to_receive_n <= 1'b1;
      end else if (cfg_reg[`SCU_CFG_AUTO]) begin
         if (rx_room <= {{FIFO_LOG2{1'b0}}, 1'b1}) begin
            o_ready_to_receive_n <= 1'b1;
         end else begin
            o_ready_to_receive_n <= 1'b0;
         end
      end else begin
         o_ready_to_receive_n <= ~cfg_reg[`SCU_CFG_RTS];
      end
   end
endmodule

// File: scu_defines.vh
// Constants for the serial controller UART block: register offsets, fields, encodings.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data, one aligned word per register.
`ifndef SCU_DEFINES_VH
`define SCU_DEFINES_VH
// Printed offsets are register indices; byte address is four times the index.
`define SCU_IDX_DATA 16'h449e
`define SCU_IDX_MODE 16'h44aa
`define SCU_IDX_CFG 16'h44ae
`define SCU_IDX_PER 16'h44b4
`define SCU_IDX_FRAC 16'h44b6
`define SCU_ADDR_W 18
// Mode encodings.
`define SCU_MODE_OFF 2'h0
`define SCU_MODE_UART 2'h1
`define SCU_MODE_SPI 2'h2
`define SCU_MODE_I2C 2'h3
// Configuration field positions.
`define SCU_CFG_RTS 0
`define SCU_CFG_8BIT 1
`define SCU_CFG_2STP 2
`define SCU_CFG_PAR 3
`define SCU_CFG_ODD 4
`define SCU_CFG_FLOW 5
`define SCU_CFG_AUTO 6
`define SCU_CFG_W 7
// Reset values.
`define SCU_RST_MODE 2'h0
`define SCU_RST_CFG 7'h00
`define SCU_RST_PER 16'h0000
`define SCU_RST_FRAC 1'h0
`endif

// File: scu_fifo.v
// Synchronous byte FIFO used for both the transmit and receive directions.
// Assumes one clock; push when full is ignored unless a pop comes in the same cycle, and pop when empty is ignored.
`include "scu_defines.vh"
module scu_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH_LOG2 = 2
) (
   input wire i_clock,
   input wire i_resetn,
   input wire i_clear,
   input wire i_push,
   input wire [WIDTH-1:0] i_data,
   input wire i_pop,
   output wire [WIDTH-1:0] o_data,
   output wire o_empty,
   output wire o_full,
   output wire [DEPTH_LOG2:0] o_count
);
   localparam DEPTH = 1 << DEPTH_LOG2;
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [DEPTH_LOG2-1:0] wr_reg;
   reg [DEPTH_LOG2-1:0] rd_reg;
   reg [DEPTH_LOG2:0] count_reg;
   wire do_push = i_push && (count_reg != DEPTH[DEPTH_LOG2:0] || i_pop);
   wire do_pop = i_pop && (count_reg != {(DEPTH_LOG2+1){1'b0}});

   // Storage array is written without reset.
   always @(posedge i_clock) begin
      if (do_push) begin
         mem[wr_reg] <= i_data;
      end
   end

   // Pointers and occupancy count.
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_reg <= {DEPTH_LOG2{1'b0}};
         rd_reg <= {DEPTH_LOG2{1'b0}};
         count_reg <= {(DEPTH_LOG2+1){1'b0}};
      end else if (i_clear) begin
         wr_reg <= {DEPTH_LOG2{1'b0}};
         rd_reg <= {DEPTH_LOG2{1'b0}};
         count_reg <= {(DEPTH_LOG2+1){1'b0}};
      end else begin
         if (do_push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (do_pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (do_pop && !do_push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   assign o_data = mem[rd_reg];
   assign o_empty = (count_reg == {(DEPTH_LOG2+1){1'b0}});
   assign o_full = (count_reg == DEPTH[DEPTH_LOG2:0]);
   assign o_count = count_reg;
endmodule

// File: scu_baud.v
// Half-bit tick generator: one tick every N+0.5*F reference cycles, alternating rounding.
// Assumes the system clock is the 24 MHz reference the rate equation names.
`include "scu_defines.vh"
module scu_baud (
   input wire i_clock,
   input wire i_resetn,
   input wire i_run,
   input wire [15:0] i_period,
   input wire i_frac,
   output reg o_tick
);
   reg [15:0] cnt_reg;
   reg half_reg;
   // Fraction adds one cycle on every other half-bit, giving N+F/2 on average.
   wire [16:0] limit = {1'b0, i_period} + {16'h0000, (i_frac & half_reg)};

   // Counts reference cycles and pulses at each half-bit boundary.
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_reg <= 16'h0000;
         half_reg <= 1'b0;
         o_tick <= 1'b0;
      end else if (!i_run) begin
         cnt_reg <= 16'h0000;
         half_reg <= 1'b0;
         o_tick <= 1'b0;
      end else if ({1'b0, cnt_reg} + 17'h00001 >= limit) begin
         cnt_reg <= 16'h0000;
         half_reg <= ~half_reg;
         o_tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         o_tick <= 1'b0;
      end
   end
endmodule

// File: scu_uart_assertions.sv
// Checker for scu_uart: bus answer timing, register readback, line idle and request-to-send.
// Assumes it is bound to scu_uart and sees only that module's ports.
`include "scu_defines.vh"
module scu_uart_assertions (
   input wire i_clock,
   input wire i_resetn,
   input wire [`SCU_ADDR_W-1:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [31:0] i_writedata,
   input wire [31:0] o_readdata,
   input wire o_waitrequest,
   input wire o_tx,
   input wire o_ready_to_receive_n
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [6:0] cfg_reg;
   reg [15:0] per_reg;
   reg [1:0] mode_reg;
   wire [15:0] idx = i_address[17:2];
   wire done = !o_waitrequest;
   wire rd_done = done && i_read;
   // Mirror the mode, format and period registers from completed bus writes.
   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_reg <= `SCU_RST_CFG;
         per_reg <= `SCU_RST_PER;
         mode_reg <= `SCU_RST_MODE;
      end else if (i_write && done) begin
         if (idx == `SCU_IDX_CFG) cfg_reg <= i_writedata[6:0];
         if (idx == `SCU_IDX_PER) per_reg <= i_writedata[15:0];
         if (idx == `SCU_IDX_MODE) mode_reg <= i_writedata[1:0];
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   // A fresh request gets one wait cycle, and the answer lasts one cycle.
   property p_answer; (i_read || i_write) && !$past(i_read || i_write) |=> done; endproperty
   a_answer: assert property (p_answer) else $error("Answer late.");
   property p_one; done |=> !done; endproperty
   a_one: assert property (p_one) else $error("Answer too long.");
   // Period and format readback match the written value; fraction keeps unused bits at zero and data reads zero outside UART mode.
   property p_per; rd_done && idx == `SCU_IDX_PER |-> o_readdata == {16'h0, per_reg}; endproperty
   a_per: assert property (p_per) else $error("Period readback wrong.");
   property p_frac; rd_done && idx == `SCU_IDX_FRAC |-> o_readdata[31:1] == 31'h0; endproperty
   a_frac: assert property (p_frac) else $error("Fraction readback wrong.");
   property p_cfg; rd_done && idx == `SCU_IDX_CFG |-> o_readdata == {25'h0, cfg_reg}; endproperty
   a_cfg: assert property (p_cfg) else $error("Format readback wrong.");
   property p_off_data; rd_done && idx == `SCU_IDX_DATA && mode_reg != 2'h1 |-> o_readdata == 32'h0; endproperty
   a_off_data: assert property (p_off_data) else $error("Data read outside UART mode.");
   // The line idles high while UART mode is off.
   property p_idle; mode_reg != 2'h1 && $past(mode_reg) != 2'h1 |-> o_tx; endproperty
   a_idle: assert property (p_idle) else $error("Line active outside UART mode.");
   // Request-to-send is off without handshake and follows software in manual mode.
   property p_rts_off; !cfg_reg[5] && !$past(cfg_reg[5]) |-> o_ready_to_receive_n; endproperty
   a_rts_off: assert property (p_rts_off) else $error("Request asserted without handshake.");
   property p_rts_sw; mode_reg == 2'h1 && $stable(mode_reg) && cfg_reg[5] && !cfg_reg[6] && $stable(cfg_reg)
      |-> o_ready_to_receive_n == !cfg_reg[0];
   endproperty
   a_rts_sw: assert property (p_rts_sw) else $error("Request ignores software level.");
endmodule
bind scu_uart scu_uart_assertions i_scu_uart_assertions (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_tx(o_tx),
   .o_ready_to_receive_n(o_ready_to_receive_n));

// File: scu_partner.sv
// Remote serial device: frames bytes onto the receive line and decodes the transmit line.
// Assumes the bench sets bit_t (clocks a bit) and nbits (data plus parity) between frames.
module scu_partner (
   input wire i_clock,
   input wire i_tx,
   input wire i_ready_to_receive_n,
   output logic o_rx,
   output logic o_clear_to_send_in_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int bit_t = 4;
   int nbits = 8;
   int lo_run = 0;
   int hi_run = 0;
   int run = 0;
   int bad_stop = 0;
   logic last = 1'b1;
   logic [15:0] got[$];
   // The receive line idles high and sending is allowed until the bench says otherwise.
   initial begin
      o_rx = 1'b1;
      o_clear_to_send_in_n = 1'b0;
   end
   // Time every low and high run on the transmit line in clocks.
   always @(posedge i_clock) begin
      if (i_tx !== last) begin
         if (last) hi_run = run;
         else lo_run = run;
         run = 1;
      end else begin
         run++;
      end
      last = i_tx;
   end
   // Decode each frame, sampling in mid-bit after the falling start edge.
   initial forever begin
      logic [15:0] b;
      @(negedge i_tx);
      repeat (bit_t / 2) @(posedge i_clock);
      b = 16'h0;
      for (int i = 0; i < nbits; i++) begin
         repeat (bit_t) @(posedge i_clock);
         b[i] = i_tx;
      end
      repeat (bit_t) @(posedge i_clock);
      if (i_tx !== 1'b1) bad_stop++;
      got.push_back(b);
   end
   // Send one frame, holding off while the device asks us to wait.
   task automatic send(input [7:0] d);
      while (i_ready_to_receive_n !== 1'b0) @(posedge i_clock);
      for (int i = -1; i < 9; i++) begin
         o_rx <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : d[i];
         repeat (bit_t) @(posedge i_clock);
      end
   endtask
endmodule

// File: tb.sv
// Self-checking bench for scu_uart: registers, modes, framing, baud timing and flow control.
// Assumes scu_partner on the serial pins and the checker bound to the block.
`include "scu_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam [15:0] DP = `SCU_IDX_DATA;
   localparam [15:0] MD = `SCU_IDX_MODE;
   localparam [15:0] CF = `SCU_IDX_CFG;
   localparam [15:0] PR = `SCU_IDX_PER;
   localparam [15:0] FR = `SCU_IDX_FRAC;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [17:0] addr = 18'h0;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   wire [31:0] rdata;
   wire wreq, tx, rx, cts_n, rts_n;
   int fail_count = 0;
   int samples_checked = 0;
   logic [15:0] v;
   logic [15:0] regs [6] = '{DP, MD, CF, PR, FR, 16'h44a0};
   always #5 clock = ~clock;
   // The block with its serial partner.
   scu_uart #(.FIFO_LOG2(2)) i_scu_uart (.i_clock(clock), .i_resetn(resetn), .i_address(addr), .i_read(rd_en),
      .i_write(wr_en), .i_writedata(wdata), .i_byteenable(4'hf), .o_readdata(rdata), .o_waitrequest(wreq),
      .i_rx(rx), .i_clear_to_send_in_n(cts_n), .o_tx(tx), .o_ready_to_receive_n(rts_n));
   scu_partner i_scu_partner (.i_clock(clock), .i_tx(tx), .i_ready_to_receive_n(rts_n), .o_rx(rx),
      .o_clear_to_send_in_n(cts_n));
   // One bus transfer, held until waitrequest is seen low.
   task automatic bus(input logic w, input [15:0] idx, input [15:0] d);
      @(posedge clock);
      addr <= {idx, 2'b00};
      wdata <= {16'h0, d};
      rd_en <= !w;
      wr_en <= w;
      @(posedge clock);
      while (wreq !== 1'b0) @(posedge clock);
      v = rdata[15:0];
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task automatic chk(input [15:0] got, input [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input [15:0] idx, input [15:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rdchk(input [15:0] idx, input [15:0] exp);
      bus(1'b0, idx, 16'h0);
      chk(v, exp);
   endtask
   task automatic rts(input logic e);
      repeat (2) @(posedge clock);
      chk({15'h0, rts_n}, {15'h0, e});
   endtask
   // Wait for the partner to decode a frame and compare it.
   task automatic tx_chk(input [15:0] exp);
      for (int i = 0; i < 4000 && i_scu_partner.got.size() == 0; i++) @(posedge clock);
      v = 16'hdead;
      if (i_scu_partner.got.size() > 0) v = i_scu_partner.got.pop_front();
      chk(v, exp);
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Cut a hang short well beyond the expected run of roughly a thousand cycles.
   initial begin
      repeat (30000) @(posedge clock);
      fail_count++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      foreach (regs[i]) rdchk(regs[i], 16'h0);
      wr(CF, 16'hffff);
      rdchk(CF, 16'h7f);
      wr(FR, 16'hffff);
      rdchk(FR, 16'h1);
      wr(PR, 16'ha5c3);
      rdchk(PR, 16'ha5c3);
      wr(16'h44a0, 16'hffff);
      rdchk(16'h44a0, 16'h0);
      // Four clocks a bit, eight data bits, no handshake; only UART mode sends.
      wr(PR, 16'h2);
      wr(FR, 16'h0);
      wr(CF, 16'h2);
      for (int m = 0; m < 4; m++) begin
         wr(MD, 16'h0);
         wr(MD, 16'(m));
         rdchk(MD, 16'(m));
         wr(DP, 16'h11);
         if (m == 1) tx_chk(16'h11);
      end
      repeat (100) @(posedge clock);
      chk(16'(i_scu_partner.got.size()), 16'h0);
      wr(MD, 16'h0);
      wr(MD, 16'h1);
      // Back-to-back pushes leave in order at four clocks a bit.
      wr(DP, 16'h55);
      wr(DP, 16'h0f);
      wr(DP, 16'ha0);
      tx_chk(16'h55);
      chk(16'(i_scu_partner.lo_run), 16'd4);
      tx_chk(16'h0f);
      tx_chk(16'ha0);
      // Half a unit of fraction stretches each bit to five clocks.
      i_scu_partner.bit_t = 5;
      wr(FR, 16'h1);
      wr(DP, 16'h55);
      tx_chk(16'h55);
      chk(16'(i_scu_partner.lo_run), 16'd5);
      i_scu_partner.bit_t = 4;
      wr(FR, 16'h0);
      // Even and odd parity follow the data; seven-bit frames drop the top bit.
      i_scu_partner.nbits = 9;
      wr(CF, 16'h0a);
      wr(DP, 16'h03);
      tx_chk(16'h003);
      wr(CF, 16'h1a);
      wr(DP, 16'h03);
      tx_chk(16'h103);
      i_scu_partner.nbits = 7;
      wr(CF, 16'h0);
      wr(DP, 16'hb5);
      tx_chk(16'h35);
      // Two stop bits leave eight idle clocks between frames of zeros.
      i_scu_partner.nbits = 8;
      wr(CF, 16'h06);
      wr(DP, 16'h0);
      wr(DP, 16'h0);
      tx_chk(16'h0);
      tx_chk(16'h0);
      chk(16'(i_scu_partner.lo_run), 16'd36);
      chk(16'(i_scu_partner.hi_run), 16'd8);
      // Request-to-send: off, software level, then automatic on buffer room.
      wr(CF, 16'h02);
      rts(1'b1);
      wr(CF, 16'h23);
      rts(1'b0);
      wr(CF, 16'h22);
      rts(1'b1);
      wr(CF, 16'h62);
      rts(1'b0);
      i_scu_partner.send(8'h3c);
      i_scu_partner.send(8'hc3);
      i_scu_partner.send(8'h5a);
      rts(1'b1);
      rdchk(DP, 16'h3c);
      rts(1'b0);
      rdchk(DP, 16'hc3);
      rdchk(DP, 16'h5a);
      rdchk(DP, 16'h0);
      // Clear-to-send holds the transmitter only while the handshake is on.
      i_scu_partner.o_clear_to_send_in_n <= 1'b1;
      wr(CF, 16'h23);
      wr(DP, 16'h77);
      repeat (100) @(posedge clock);
      chk(16'(i_scu_partner.got.size()), 16'h0);
      i_scu_partner.o_clear_to_send_in_n <= 1'b0;
      tx_chk(16'h77);
      i_scu_partner.o_clear_to_send_in_n <= 1'b1;
      wr(CF, 16'h03);
      wr(DP, 16'h78);
      tx_chk(16'h78);
      chk(16'(i_scu_partner.bad_stop), 16'h0);
      print_verdict();
   end
endmodule
